// File: design/host_port.sv
/*
 * Host pin interface of a TFT display driver: parallel, serial and RGB ports.
 * Assumes the bus, strap, RGB timing and reset pins are asynchronous to mclk_i and the core answers reads
 * one cycle after a read request.
 */
`timescale 1ns/1ns

module host_port
   import host_port_pkg::*;
#(
   parameter logic [4:0] ID_UPPER   = ID_UPPER_DEFAULT,
   parameter int         FRAME_CNT  = FRAME_CYCLES
)
(
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      hardware_reset_n_i,
   input  wire logic [3:0]                interface_strap_pins_i,
   input  wire logic                      chip_select_n_i,
   input  wire logic                      index_or_command_select_i,
   input  wire logic                      write_strobe_or_enable_i,
   input  wire logic                      read_strobe_or_direction_i,
   input  wire logic [17:0]               parallel_data_lanes_i,
   output      logic [17:0]               parallel_data_lanes_o,
   output      logic [17:0]               parallel_data_lanes_oe_o,
   input  wire logic                      serial_clock_i,
   input  wire logic                      serial_in_i,
   output      logic                      serial_out_o,
   input  wire logic                      rgb_mode_i,
   input  wire logic                      pixel_clock_pin_i,
   input  wire logic                      pixel_enable_i,
   input  wire logic                      frame_sync_i,
   input  wire logic                      line_sync_i,
   input  wire logic                      pixel_enable_polarity_i,
   input  wire logic                      frame_sync_polarity_i,
   input  wire logic                      line_sync_polarity_i,
   input  wire logic                      pixel_clock_edge_select_i,
   input  wire logic                      source_scan_reverse_i,
   input  wire logic                      oscillator_ext_select_i,
   input  wire logic [17:0]               core_rd_data_i,
   output      host_port_pkg::host_wr_s   host_wr_o,
   output      logic                      rd_req_o,
   output      logic                      rd_index_o,
   output      host_port_pkg::pixel_wr_s  pixel_wr_o,
   output      logic                      frame_head_pulse_o,
   output      host_port_pkg::mode_s      mode_o,
   output      logic                      clock_source_ext_o
);
   import host_port_pkg::*;

   pins_s       pin_raw;
   pins_s       s1_r;
   pins_s       s2_r;
   pins_s       d_r;
   logic        rst;
   logic        sel;
   logic        cs_fall;
   logic        cs_rise;
   logic        scl_rise;
   logic        scl_fall;
   logic        par;
   logic        narrow;
   logic        wr_done;
   logic        rd_start;
   logic        rd_active;
   logic        pix_edge;
   logic        vs_start;
   logic        hs_start;
   logic [7:0]  sbyte;

   mode_s       mode_r,       mode_nxt;
   logic        half_r,       half_nxt;
   logic [8:0]  hi_r,         hi_nxt;
   logic [17:0] latch_r,      latch_nxt;
   logic [17:0] lanes_r,      lanes_nxt;
   logic [17:0] oe_r,         oe_nxt;
   host_wr_s    wr_r,         wr_nxt;
   logic        rd_req_r,     rd_req_nxt;
   logic        rd_idx_r,     rd_idx_nxt;
   logic        rd_pend_r,    rd_pend_nxt;
   ser_e        ser_r,        ser_nxt;
   logic [3:0]  cnt_r,        cnt_nxt;
   logic [15:0] sin_r,        sin_nxt;
   logic        sidx_r,       sidx_nxt;
   logic        srd_r,        srd_nxt;
   logic [23:0] sout_r,       sout_nxt;
   logic        sdo_r,        sdo_nxt;
   pixel_wr_s   pix_r,        pix_nxt;
   logic [7:0]  row_r,        row_nxt;
   logic [6:0]  col_r,        col_nxt;
   logic [20:0] fcnt_r,       fcnt_nxt;
   logic        flm_r,        flm_nxt;
   logic        ext_r,        ext_nxt;

   assign pin_raw = '{interface_strap_pins_i, chip_select_n_i,
                      index_or_command_select_i, write_strobe_or_enable_i,
                      read_strobe_or_direction_i, serial_clock_i, serial_in_i,
                      pixel_clock_pin_i, pixel_enable_i, frame_sync_i,
                      line_sync_i, parallel_data_lanes_i, hardware_reset_n_i};

   // Two-flop synchroniser for the bus, strap, RGB timing and hardware reset pins, plus a delayed copy for edges.
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         s1_r <= PINS_RESET;
         s2_r <= PINS_RESET;
         d_r  <= PINS_RESET;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         d_r  <= s2_r;
      end
   end

   assign rst       = !rst_n_i || !s2_r.hw_n;
   assign sel       = !s2_r.cs_n;
   assign cs_fall   = d_r.cs_n && !s2_r.cs_n;
   assign cs_rise   = !d_r.cs_n && s2_r.cs_n;
   assign scl_rise  = !d_r.scl && s2_r.scl;
   assign scl_fall  = d_r.scl && !s2_r.scl;
   assign par       = (mode_r.bus == BUS_68) || (mode_r.bus == BUS_80);
   assign narrow    = (mode_r.width == W8) || (mode_r.width == W9);
   assign wr_done   = par && sel && ((mode_r.bus == BUS_80)
                      ? (!d_r.wr && s2_r.wr)
                      : (d_r.wr && !s2_r.wr && !d_r.rd));
   assign rd_start  = par && sel && ((mode_r.bus == BUS_80)
                      ? (d_r.rd && !s2_r.rd)
                      : (!d_r.wr && s2_r.wr && s2_r.rd));
   assign rd_active = par && sel && ((mode_r.bus == BUS_80)
                      ? !s2_r.rd
                      : (s2_r.wr && s2_r.rd));
   assign pix_edge  = (s2_r.pclk != d_r.pclk)
                      && (s2_r.pclk == pixel_clock_edge_select_i);
   assign vs_start  = (s2_r.vs == frame_sync_polarity_i)
                      && (d_r.vs != frame_sync_polarity_i);
   assign hs_start  = (s2_r.hs == line_sync_polarity_i)
                      && (d_r.hs != line_sync_polarity_i);
   assign sbyte     = {sin_r[6:0], s2_r.serial_in};

   always_comb
   begin
      mode_nxt    = decode_mode(s2_r.strap);
      half_nxt    = half_r;
      hi_nxt      = hi_r;
      latch_nxt   = latch_r;
      lanes_nxt   = lanes_r;
      oe_nxt      = {18{rd_active}};
      wr_nxt      = '0;
      rd_req_nxt  = 1'b0;
      rd_idx_nxt  = rd_idx_r;
      ser_nxt     = ser_r;
      cnt_nxt     = cnt_r;
      sin_nxt     = sin_r;
      sidx_nxt    = sidx_r;
      srd_nxt     = srd_r;
      sout_nxt    = sout_r;
      sdo_nxt     = sdo_r;
      pix_nxt     = pix_r;
      pix_nxt.valid = 1'b0;
      row_nxt     = row_r;
      col_nxt     = col_r;
      fcnt_nxt    = fcnt_r;
      flm_nxt     = 1'b0;
      ext_nxt     = oscillator_ext_select_i;

      if (rd_pend_r)
      begin
         latch_nxt = core_rd_data_i;
      end

      // Parallel write: lanes are taken from the cycle before the strobe edge.
      if (wr_done)
      begin
         wr_nxt.index = d_r.rs;
         latch_nxt    = '0;
         case (mode_r.width)
            W18: wr_nxt = '{1'b1, d_r.rs, d_r.lanes};
            W16: wr_nxt = '{1'b1, d_r.rs,
                            {2'b00, d_r.lanes[17:10], d_r.lanes[8:1]}};
            W9:
            begin
               if (half_r)
               begin
                  wr_nxt = '{1'b1, d_r.rs, {hi_r, d_r.lanes[17:9]}};
               end
               hi_nxt   = d_r.lanes[17:9];
               half_nxt = !half_r;
            end
            default:
            begin
               if (half_r)
               begin
                  wr_nxt = '{1'b1, d_r.rs,
                             {2'b00, hi_r[7:0], d_r.lanes[17:10]}};
               end
               hi_nxt   = {1'b0, d_r.lanes[17:10]};
               half_nxt = !half_r;
            end
         endcase
      end

      // Parallel read: the latch shows the previous answer, so the first is a dummy.
      if (rd_start)
      begin
         if (!narrow || !half_r)
         begin
            rd_req_nxt = 1'b1;
            rd_idx_nxt = s2_r.rs;
         end
         case (mode_r.width)
            W18: lanes_nxt = latch_r;
            W16: lanes_nxt = {latch_r[15:8], 1'b0, latch_r[7:0], 1'b0};
            W9:  lanes_nxt = half_r ? {latch_r[8:0], 9'h000}
                                    : {latch_r[17:9], 9'h000};
            default: lanes_nxt = half_r ? {latch_r[7:0], 10'h000}
                                        : {latch_r[15:8], 10'h000};
         endcase
         if (narrow)
         begin
            half_nxt = !half_r;
         end
      end

      if (cs_rise)
      begin
         half_nxt = 1'b0;
      end

      // Serial transfer framed by chip select, most significant bit first.
      case (ser_r)
         SER_IDLE:
         begin
            if (cs_fall && mode_r.bus == BUS_SERIAL)
            begin
               ser_nxt = SER_START;
               cnt_nxt = '0;
            end
         end
         SER_START:
         begin
            if (scl_rise)
            begin
               sin_nxt = {sin_r[14:0], s2_r.serial_in};
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == BYTE_LAST)
               begin
                  cnt_nxt  = '0;
                  sidx_nxt = sbyte[1];
                  srd_nxt  = sbyte[0];
                  ser_nxt  = SER_SKIP;
                  if (sbyte[7:2] == {ID_UPPER, mode_r.id_bit})
                  begin
                     ser_nxt    = SER_DATA;
                     rd_req_nxt = sbyte[0];
                     rd_idx_nxt = sbyte[1];
                  end
               end
            end
         end
         SER_DATA:
         begin
            if (srd_r)
            begin
               if (rd_pend_r)
               begin
                  sout_nxt = {8'h00, core_rd_data_i[15:0]};
               end
               if (scl_fall)
               begin
                  sdo_nxt  = sout_r[23];
                  sout_nxt = {sout_r[22:0], 1'b0};
               end
            end
            else if (scl_rise)
            begin
               sin_nxt = {sin_r[14:0], s2_r.serial_in};
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == WORD_LAST)
               begin
                  wr_nxt    = '{1'b1, sidx_r, {2'b00, sin_r[14:0], s2_r.serial_in}};
                  latch_nxt = '0;
               end
            end
         end
         default:
         begin
            ser_nxt = ser_r;
         end
      endcase
      if (cs_rise || mode_r.bus != BUS_SERIAL)
      begin
         ser_nxt  = SER_IDLE;
         sdo_nxt  = 1'b0;
         sout_nxt = SER_OUT_RESET;
      end

      // RGB port: frame sync start clears the address, line sync start clears the column and steps the row, enable gates the write.
      if (rgb_mode_i)
      begin
         if (vs_start)
         begin
            row_nxt = '0;
            col_nxt = '0;
            flm_nxt = 1'b1;
         end
         else if (hs_start)
         begin
            row_nxt = row_r + 8'h01;
            col_nxt = '0;
         end
         else if (pix_edge && (s2_r.pen == pixel_enable_polarity_i))
         begin
            pix_nxt.valid  = 1'b1;
            pix_nxt.row    = row_r;
            pix_nxt.col    = col_r;
            pix_nxt.data   = d_r.lanes;
            pix_nxt.source = source_scan_reverse_i
                             ? SOURCE_LAST - {2'b00, col_r} * SUBPIXELS
                             : {2'b00, col_r} * SUBPIXELS;
            col_nxt        = col_r + 7'h01;
         end
         fcnt_nxt = '0;
      end
      else if (fcnt_r == 21'(FRAME_CNT - 1))
      begin
         fcnt_nxt = '0;
         flm_nxt  = 1'b1;
      end
      else
      begin
         fcnt_nxt = fcnt_r + 21'h000001;
      end
   end

   assign rd_pend_nxt = rd_req_r;

   always_ff @(posedge mclk_i)
   begin
      if (rst)
      begin
         mode_r    <= MODE_RESET;
         half_r    <= 1'b0;
         hi_r      <= '0;
         latch_r   <= '0;
         lanes_r   <= '0;
         oe_r      <= '0;
         wr_r      <= '0;
         rd_req_r  <= 1'b0;
         rd_idx_r  <= 1'b0;
         rd_pend_r <= 1'b0;
         ser_r     <= SER_IDLE;
         cnt_r     <= '0;
         sin_r     <= '0;
         sidx_r    <= 1'b0;
         srd_r     <= 1'b0;
         sout_r    <= SER_OUT_RESET;
         sdo_r     <= 1'b0;
         pix_r     <= '0;
         row_r     <= '0;
         col_r     <= '0;
         fcnt_r    <= '0;
         flm_r     <= 1'b0;
         ext_r     <= 1'b0;
      end
      else
      begin
         mode_r    <= mode_nxt;
         half_r    <= half_nxt;
         hi_r      <= hi_nxt;
         latch_r   <= latch_nxt;
         lanes_r   <= lanes_nxt;
         oe_r      <= oe_nxt;
         wr_r      <= wr_nxt;
         rd_req_r  <= rd_req_nxt;
         rd_idx_r  <= rd_idx_nxt;
         rd_pend_r <= rd_pend_nxt;
         ser_r     <= ser_nxt;
         cnt_r     <= cnt_nxt;
         sin_r     <= sin_nxt;
         sidx_r    <= sidx_nxt;
         srd_r     <= srd_nxt;
         sout_r    <= sout_nxt;
         sdo_r     <= sdo_nxt;
         pix_r     <= pix_nxt;
         row_r     <= row_nxt;
         col_r     <= col_nxt;
         fcnt_r    <= fcnt_nxt;
         flm_r     <= flm_nxt;
         ext_r     <= ext_nxt;
      end
   end

   assign parallel_data_lanes_o    = lanes_r;
   assign parallel_data_lanes_oe_o = oe_r;
   assign serial_out_o             = sdo_r;
   assign host_wr_o                = wr_r;
   assign rd_req_o                 = rd_req_r;
   assign rd_index_o               = rd_idx_r;
   assign pixel_wr_o               = pix_r;
   assign frame_head_pulse_o       = flm_r;
   assign mode_o                   = mode_r;
   assign clock_source_ext_o       = ext_r;

endmodule

// File: design/host_port_pkg.sv
/*
 * Shared types and constants for the display driver host pin interface.
 * Assumes a single 100 MHz internal clock and a core that owns the RAM.
 */
package host_port_pkg;

   typedef enum logic [3:0] {
      BUS_68      = 4'b0001,
      BUS_80      = 4'b0010,
      BUS_SERIAL  = 4'b0100,
      BUS_INVALID = 4'b1000
   } bus_e;

   typedef enum logic [3:0] {
      W8  = 4'b0001,
      W9  = 4'b0010,
      W16 = 4'b0100,
      W18 = 4'b1000
   } width_e;

   typedef enum logic [3:0] {
      SER_IDLE  = 4'b0001,
      SER_START = 4'b0010,
      SER_DATA  = 4'b0100,
      SER_SKIP  = 4'b1000
   } ser_e;

   typedef struct packed {
      bus_e       bus;
      width_e     width;
      logic       id_bit;
   } mode_s;

   typedef struct packed {
      logic        valid;
      logic        index;
      logic [17:0] data;
   } host_wr_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  row;
      logic [6:0]  col;
      logic [8:0]  source;
      logic [17:0] data;
   } pixel_wr_s;

   typedef struct packed {
      logic [3:0]  strap;
      logic        cs_n;
      logic        rs;
      logic        wr;
      logic        rd;
      logic        scl;
      logic        serial_in;
      logic        pclk;
      logic        pen;
      logic        vs;
      logic        hs;
      logic [17:0] lanes;
      logic        hw_n;
   } pins_s;

   // Identification upper bits: arbitrary neutral value.
   localparam logic [4:0]  ID_UPPER_DEFAULT = 5'h15;
   localparam logic [8:0]  SOURCE_LAST      = 9'h17f;
   localparam logic [8:0]  SUBPIXELS        = 9'h003;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          FRAME_TIME_NS    = 16_666_660;
   localparam int          FRAME_CYCLES     = FRAME_TIME_NS / CLK_PERIOD_NS;
   localparam logic [3:0]  BYTE_LAST        = 4'h7;
   localparam logic [3:0]  WORD_LAST        = 4'hf;
   localparam logic [23:0] SER_OUT_RESET    = 24'h000000;
   localparam mode_s       MODE_RESET       = '{BUS_INVALID, W8, 1'b0};
   localparam pins_s       PINS_RESET       = '{4'h0, 1'b1, 1'b0, 1'b1,
                                                1'b1, 1'b0, 1'b0, 1'b0,
                                                1'b0, 1'b0, 1'b0,
                                                18'h00000, 1'b0};

   function automatic mode_s decode_mode(input logic [3:0] p);
      mode_s m;
      m.id_bit = p[0];
      m.bus    = p[1] ? BUS_80 : BUS_68;
      m.width  = p[3] ? (p[0] ? W9 : W18) : (p[0] ? W8 : W16);
      if (p[2])
      begin
         m.bus = (!p[3] && !p[1]) ? BUS_SERIAL : BUS_INVALID;
      end
      return m;
   endfunction

endpackage

// File: verification/host_model.sv
/* Behavioural host processor driving the parallel and serial pins.
   Assumes the bench resolves the shared data lanes from the port's output enables. */
`timescale 1ns/1ns
module host_model
(
   input  wire logic        mclk_i,
   input  wire logic        serial_out_i,
   input  wire logic [17:0] lanes_i,
   output      logic        cs_n_o = 1'b1,
   output      logic        rs_o = 1'b0,
   output      logic        wr_o = 1'b1,
   output      logic        rd_o = 1'b1,
   output      logic        scl_o = 1'b0,
   output      logic        sdi_o = 1'b0,
   output      logic [17:0] lanes_o = 18'h00000
);
   task automatic half();
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic idle(input logic m68);
      wr_o = ~m68;
      rd_o = 1'b1;
      half();
   endtask
   task automatic sel(input logic on);
      half();
      cs_n_o = ~on;
      half();
   endtask
   task automatic wr_cycle(input logic m68, input logic r, input logic [17:0] d);
      rs_o = r;
      lanes_o = d;
      rd_o = ~m68;
      half();
      wr_o = m68;
      half();
      wr_o = ~m68;
      half();
      lanes_o = ~d;
      rd_o = 1'b1;
   endtask
   task automatic rd_cycle(input logic m68, input logic r, output logic [17:0] q);
      rs_o = r;
      half();
      wr_o = 1'b1;
      rd_o = m68;
      repeat (2) half();
      q = lanes_i;
      wr_o = ~m68;
      rd_o = 1'b1;
      half();
   endtask
   task automatic shift(input logic [31:0] v, input int n, output logic [31:0] q);
      q = 32'h00000000;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi_o = v[i];
         half();
         scl_o = 1'b1;
         @(negedge mclk_i);
         q = {q[30:0], serial_out_i};
         repeat (3) @(negedge mclk_i);
         scl_o = 1'b0;
      end
      sdi_o = ~sdi_o;
   endtask
endmodule

// File: verification/host_port_assertions.sv
/* Port checker for the host pin interface.
   Assumes it is bound into host_port and sees its ports by name. */
`timescale 1ns/1ns
module host_port_assertions
   import host_port_pkg::*;
(
   input wire logic                     mclk_i,
   input wire logic                     rst_n_i,
   input wire logic                     hardware_reset_n_i,
   input wire logic [3:0]               interface_strap_pins_i,
   input wire logic                     chip_select_n_i,
   input wire logic                     pixel_enable_i,
   input wire logic                     pixel_enable_polarity_i,
   input wire logic                     source_scan_reverse_i,
   input wire logic [17:0]              parallel_data_lanes_oe_o,
   input wire logic                     serial_out_o,
   input wire logic                     frame_head_pulse_o,
   input wire host_port_pkg::host_wr_s  host_wr_o,
   input wire host_port_pkg::pixel_wr_s pixel_wr_o,
   input wire host_port_pkg::mode_s     mode_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence cs_idle;
      chip_select_n_i [*8];
   endsequence
   sequence hw_held;
      !hardware_reset_n_i [*6];
   endsequence
   sequence straps_steady;
      (hardware_reset_n_i && $stable(interface_strap_pins_i)) [*8];
   endsequence
   AST_CS_GATE: assert property (cs_idle |-> !host_wr_o.valid)
      else $error("write taken while deselected");
   AST_OE_IDLE: assert property (cs_idle |-> parallel_data_lanes_oe_o == 18'h00000)
      else $error("lanes driven while deselected");
   AST_SDO_IDLE: assert property (cs_idle |-> !serial_out_o)
      else $error("serial output active outside a transfer");
   AST_HW_RESET: assert property (hw_held |-> !host_wr_o.valid && !pixel_wr_o.valid
      && !frame_head_pulse_o && mode_o.bus == BUS_INVALID) else $error("pin reset ignored");
   AST_STRAP_DECODE: assert property (straps_steady |-> mode_o.id_bit ==
      interface_strap_pins_i[0] && (mode_o.bus == BUS_SERIAL) ==
      (interface_strap_pins_i[3:1] == 3'b010)) else $error("strap decode wrong");
   AST_PIX_GATE: assert property ((pixel_enable_i != pixel_enable_polarity_i) [*6]
      |-> !pixel_wr_o.valid) else $error("pixel written while disabled");
   AST_SOURCE_MAP: assert property (pixel_wr_o.valid |-> pixel_wr_o.source ==
      (source_scan_reverse_i ? SOURCE_LAST - 9'(pixel_wr_o.col) * SUBPIXELS
      : 9'(pixel_wr_o.col) * SUBPIXELS)) else $error("source mapping wrong");
   AST_FRAME_GAP: assert property (frame_head_pulse_o |=> !frame_head_pulse_o [*8])
      else $error("frame head pulse too long or too close");
endmodule

// File: verification/test_host_port.sv
/* Self-checking bench for host_port with a host processor model.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) miss(n, 32'(e), 32'(g)); end
module test_host_port;
   import host_port_pkg::*;
   logic        mclk_i = 0, rst_n_i = 0, hardware_reset_n_i = 0, rgb_mode_i = 0;
   logic        pixel_clock_pin_i = 0, pixel_enable_i = 0, frame_sync_i = 1, line_sync_i = 1;
   logic        pixel_enable_polarity_i = 0, frame_sync_polarity_i = 0;
   logic        line_sync_polarity_i = 0, pixel_clock_edge_select_i = 1;
   logic        source_scan_reverse_i = 0, oscillator_ext_select_i = 0;
   logic [3:0]  interface_strap_pins_i = 4'h0;
   logic [17:0] core_rd_data_i = 18'h00000, host_lanes, parallel_data_lanes_o, d, d2, rq;
   logic [17:0] parallel_data_lanes_oe_o;
   logic        chip_select_n_i, index_or_command_select_i, write_strobe_or_enable_i;
   logic        read_strobe_or_direction_i, serial_clock_i, serial_in_i, serial_out_o;
   logic        rd_req_o, rd_index_o, frame_head_pulse_o, clock_source_ext_o, m68, r;
   host_wr_s    host_wr_o, wr_seen;
   pixel_wr_s   pixel_wr_o, pix_seen;
   mode_s       mode_o;
   logic [31:0] q;
   logic [3:0]  wlist [8] = '{4'ha, 4'h2, 4'hb, 4'h3, 4'h8, 4'h0, 4'h9, 4'h1};
   int          errors = 0, cmp_count = 0, wr_n = 0, rd_n = 0, pix_n = 0, fh_n = 0, n0;
   wire [17:0]  parallel_data_lanes_i = (parallel_data_lanes_oe_o & parallel_data_lanes_o)
                                        | (~parallel_data_lanes_oe_o & host_lanes);
   host_port #(.FRAME_CNT(20)) dut (.*);
   host_model host
   (
      .mclk_i, .serial_out_i(serial_out_o), .lanes_i(parallel_data_lanes_i),
      .cs_n_o(chip_select_n_i), .rs_o(index_or_command_select_i),
      .wr_o(write_strobe_or_enable_i), .rd_o(read_strobe_or_direction_i),
      .scl_o(serial_clock_i), .sdi_o(serial_in_i), .lanes_o(host_lanes)
   );
   always #5 mclk_i = ~mclk_i;
   always @(negedge mclk_i)
   begin
      if (host_wr_o.valid === 1'b1)
         wr_seen = host_wr_o;
      if (pixel_wr_o.valid === 1'b1)
         pix_seen = pixel_wr_o;
      wr_n += int'(host_wr_o.valid === 1'b1);
      rd_n += int'(rd_req_o === 1'b1);
      pix_n += int'(pixel_wr_o.valid === 1'b1);
      fh_n += int'(frame_head_pulse_o === 1'b1);
   end
   function automatic mode_s exp_mode(input logic [3:0] p);
      bus_e b;
      b = p[1] ? BUS_80 : BUS_68;
      if (p[2])
         b = (p[3:1] == 3'b010) ? BUS_SERIAL : BUS_INVALID;
      return '{b, p[3] ? (p[0] ? W9 : W18) : (p[0] ? W8 : W16), p[0]};
   endfunction
   function automatic logic [17:0] exp_word(input logic [3:0] p, input logic [17:0] a, b);
      case ({p[3], p[0]})
         2'b10: return a;
         2'b00: return {2'b00, a[17:10], a[8:1]};
         2'b11: return {a[17:9], b[17:9]};
         default: return {2'b00, a[17:10], b[17:10]};
      endcase
   endfunction
   task automatic miss(input string n, input logic [31:0] e, g);
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
   endtask
   task automatic pixel(input logic en);
      pixel_enable_i = en;
      host.half();
      pixel_clock_pin_i = pixel_clock_edge_select_i;
      host.half();
      pixel_clock_pin_i = ~pixel_clock_edge_select_i;
      host.half();
   endtask
   task automatic wrap_up();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #300_000;
      errors++;
      wrap_up();
   end
   initial
   begin
      n0 = $urandom(32'hef23dee4);
      repeat (12) @(negedge mclk_i);
      rst_n_i = 1'b1;
      hardware_reset_n_i = 1'b1;
      for (int p = 0; p < 16; p++)
      begin
         interface_strap_pins_i = 4'(p);
         repeat (10) @(negedge mclk_i);
         `CHK("mode", exp_mode(4'(p)), mode_o)
      end
      `CHK("clock source", 1'b0, clock_source_ext_o)
      foreach (wlist[k])
      begin
         interface_strap_pins_i = wlist[k];
         m68 = ~wlist[k][1];
         host.idle(m68);
         r = 1'($urandom);
         d = 18'($urandom);
         d2 = 18'($urandom);
         n0 = wr_n;
         host.sel(1'b1);
         host.wr_cycle(m68, r, d);
         if (wlist[k][0])
            host.wr_cycle(m68, r, d2);
         host.sel(1'b0);
         `CHK("write count", n0 + 1, wr_n)
         `CHK("write data", exp_word(wlist[k], d, d2), wr_seen.data)
         `CHK("write index", r, wr_seen.index)
         if (wlist[k][3] && !wlist[k][0])
         begin
            core_rd_data_i = 18'($urandom);
            n0 = rd_n;
            host.sel(1'b1);
            host.rd_cycle(m68, 1'b1, rq);
            `CHK("dummy read", 18'h00000, rq)
            host.rd_cycle(m68, 1'b1, rq);
            `CHK("read data", core_rd_data_i, rq)
            host.sel(1'b0);
            `CHK("read requests", n0 + 2, rd_n)
            `CHK("read index", 1'b1, rd_index_o)
         end
      end
      interface_strap_pins_i = 4'ha;
      host.idle(1'b0);
      n0 = wr_n;
      host.wr_cycle(1'b0, 1'b1, 18'($urandom));
      host.half();
      `CHK("deselected write", n0, wr_n)
      d = 18'($urandom);
      for (int s = 0; s < 2; s++)
      begin
         interface_strap_pins_i = {3'b010, 1'(s)};
         host.idle(1'b0);
         n0 = wr_n;
         host.sel(1'b1);
         host.shift({8'h00, ID_UPPER_DEFAULT, 3'b010, d[15:0]}, 24, q);
         host.sel(1'b0);
         `CHK("serial writes", n0 + 1 - s, wr_n)
      end
      `CHK("serial data", {2'b00, d[15:0]}, wr_seen.data)
      interface_strap_pins_i = 4'h4;
      host.idle(1'b0);
      host.sel(1'b1);
      host.shift({ID_UPPER_DEFAULT, 3'b011, 24'h000000}, 32, q);
      host.sel(1'b0);
      `CHK("serial dummy byte", 8'h00, q[23:16])
      `CHK("serial read data", core_rd_data_i[15:0], q[15:0])
      rgb_mode_i = 1'b1;
      for (int pol = 0; pol < 2; pol++)
      begin
         pixel_enable_polarity_i = 1'(pol);
         {pixel_clock_edge_select_i, source_scan_reverse_i} = 2'($urandom);
         {frame_sync_polarity_i, line_sync_polarity_i} = 2'($urandom);
         frame_sync_i = ~frame_sync_polarity_i;
         line_sync_i = ~line_sync_polarity_i;
         pixel_clock_pin_i = ~pixel_clock_edge_select_i;
         repeat (5) host.half();
         n0 = fh_n;
         frame_sync_i = frame_sync_polarity_i;
         repeat (2) host.half();
         frame_sync_i = ~frame_sync_polarity_i;
         host.half();
         `CHK("frame start", n0 + 1, fh_n)
         n0 = pix_n;
         for (int i = 0; i < 4; i++)
         begin
            pixel(pixel_enable_polarity_i ^ (i == 2));
            `CHK("pixels", n0 + i + 1 - int'(i >= 2), pix_n)
         end
         `CHK("held column", 7'h02, pix_seen.col)
         `CHK("source", source_scan_reverse_i ? 9'h179 : 9'h006, pix_seen.source)
         `CHK("pixel data", host_lanes, pix_seen.data)
         line_sync_i = line_sync_polarity_i;
         host.half();
         line_sync_i = ~line_sync_polarity_i;
         pixel(pixel_enable_polarity_i);
         `CHK("line start", 15'h0080, {pix_seen.row, pix_seen.col})
      end
      rgb_mode_i = 1'b0;
      oscillator_ext_select_i = 1'b1;
      repeat (20) @(negedge mclk_i);
      n0 = fh_n;
      repeat (100) @(negedge mclk_i);
      `CHK("frame pulses", 1'b1, (fh_n - n0) inside {[4:6]})
      `CHK("clock source", 1'b1, clock_source_ext_o)
      hardware_reset_n_i = 1'b0;
      repeat (8) @(negedge mclk_i);
      `CHK("reset mode", MODE_RESET, mode_o)
      hardware_reset_n_i = 1'b1;
      repeat (12) @(negedge mclk_i);
      `CHK("mode after reset", exp_mode(4'h4), mode_o)
      wrap_up();
   end
endmodule
bind host_port host_port_assertions chk (.*);
